// *** hdl/pmov_defines.svh ***
// constants for the playback mix and output volume block
// assumes a 100 MHz core clock and a 32-bit apb register bus
`ifndef PMOV_DEFINES_SVH
`define PMOV_DEFINES_SVH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define PMOV_IDX_ROUTE    8'h3f
`define PMOV_IDX_DACVOL   8'h23
`define PMOV_IDX_HPL      8'h24
`define PMOV_IDX_HPR      8'h25
`define PMOV_IDX_SPK      8'h26
`define PMOV_IDX_AUX      8'h27
`define PMOV_IDX_STAT     8'h28

// ************************************************************
// field positions
// ************************************************************
`define PMOV_LROUTE_LSB   3
`define PMOV_LROUTE_POS   4
`define PMOV_RROUTE_POS   2
`define PMOV_STEP_POS     0
`define PMOV_DACL_BIT     6
`define PMOV_DACR_BIT     2
`define PMOV_AMP_BIT      7

// ************************************************************
// reset values and codes
// ************************************************************
`define PMOV_ROUTE_RST    8'h14
`define PMOV_DACVOL_RST   8'h00
`define PMOV_VOL_RST      8'h7f
`define PMOV_MUTE_CODE    7'h7f
`define PMOV_FLOOR_CODE   7'h75
`define PMOV_FLOOR_ATTEN  10'h30f

// ************************************************************
// timing: one soft step per step time
// ************************************************************
`define PMOV_STEP_NS      20833
`define PMOV_CLK_MHZ      100
`define PMOV_STEP_CYC     ((`PMOV_STEP_NS * `PMOV_CLK_MHZ) / 1000)

`endif

// *** hdl/pmov_pkg.sv ***
// types shared by the playback mix and output volume block
// assumes pmov_defines.svh holds the numeric constants other than the enum codes below
package pmov_pkg;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic signed [15:0] left;
		logic signed [15:0] right;
	} pmov_stereo_t;

	typedef struct packed {
		logic       amp_route;
		logic       mute;
		logic [6:0] code;
		logic [9:0] atten;
	} pmov_drive_t;

	// ************************************************************
	// modes and states
	// ************************************************************
	typedef enum logic [1:0] {
		PMOV_SS_1X  = 2'h0,
		PMOV_SS_2X  = 2'h1,
		PMOV_SS_OFF = 2'h2,
		PMOV_SS_RSV = 2'h3
	} pmov_step_t;

	typedef enum logic [1:0] {
		PMOV_RT_OFF    = 2'h0,
		PMOV_RT_DIRECT = 2'h1,
		PMOV_RT_CROSS  = 2'h2,
		PMOV_RT_MONO   = 2'h3
	} pmov_route_t;

	typedef enum logic [1:0] {
		PMOV_R_IDLE = 2'b01,
		PMOV_R_STEP = 2'b10
	} pmov_ramp_st_t;

endpackage

// *** hdl/pmov_ramp.sv ***
// soft-step ramp of one applied volume code toward its target
// assumes tick is a one-cycle pulse once per step time
`timescale 1ns/10ps
`include "pmov_defines.svh"

module pmov_ramp
	import pmov_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// pacing and setting
	input  wire logic       tick,
	input  wire pmov_step_t mode,
	input  wire logic [6:0] target,
	// applied code
	output logic [6:0]      code,
	output logic            busy
);

	pmov_ramp_st_t state;
	logic          half;
	logic          step_now;

	// ************************************************************
	// pacing
	// ************************************************************
	assign step_now = tick && (mode != PMOV_SS_2X || half);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			half <= 1'b0;
		end else if (tick) begin
			half <= ~half;
		end
	end

	// ************************************************************
	// state and code
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= PMOV_R_IDLE;
		end else begin
			case (state)
				PMOV_R_IDLE: begin
					if (target != code && mode != PMOV_SS_OFF) begin
						state <= PMOV_R_STEP;
					end
				end
				PMOV_R_STEP: begin
					if (target == code || mode == PMOV_SS_OFF) begin
						state <= PMOV_R_IDLE;
					end
				end
				default: begin
					state <= PMOV_R_IDLE;
				end
			endcase
		end
	end

	// a new target walks the code one code a step, but jumps it to target when stepping is off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code <= 7'(`PMOV_VOL_RST);
		end else if (mode == PMOV_SS_OFF) begin
			code <= target;
		end else if (state == PMOV_R_STEP && step_now) begin
			if (code < target) begin
				code <= code + 7'h01;
			end else if (code > target) begin
				code <= code - 7'h01;
			end
		end
	end

	assign busy = (state == PMOV_R_STEP);

	// ************************************************************
	// checks
	// ************************************************************
	step_by_one_a: assert property (
		@(posedge clk) disable iff (rst)
		(mode != PMOV_SS_OFF && !$stable(code) && $past(mode) != PMOV_SS_OFF)
		|-> (code == $past(code) + 7'h01 || code == $past(code) - 7'h01))
		else $error("soft step moved by more than one code");

	off_jump_a: assert property (
		@(posedge clk) disable iff (rst)
		mode == PMOV_SS_OFF |=> code == $past(target))
		else $error("stepping off did not jump to target");

	hold_between_a: assert property (
		@(posedge clk) disable iff (rst)
		(mode != PMOV_SS_OFF && !tick) |=> $stable(code))
		else $error("code moved between step ticks");

endmodule

// *** hdl/pmov_top.sv ***
// playback digital mixers, output routing and analog volume codes
// assumes an apb master on clk and playback samples on the same clock
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "pmov_defines.svh"

// Overview of operation
// - four digital mixers, two per channel, each mixes or selects inputs.
// - the first mixer per channel gives direct, crossed or mono data.
// - the second mixer adds the key-click tone after playback level.
// - left routing sits in bits 5..4 and right in bits 3..2 of reg 0x3f.
// - converter output may feed headphone, speaker or both, own levels.
// - four drivers have their own volumes, alive with converters off.
// - headphone volume spans 0 dB to about -78 dB and is soft stepped.
// - bit 6 of reg 0x23 connects the left converter to its volume stage.
// - left headphone code is bits 6..0 of 0x24, right of 0x25.
// - bit 7 of 0x24 and 0x25 routes the volume stage to its amplifier.
// - bits 1..0 of reg 0x3f select the soft-stepping time.
// - code 0 is 0 dB, codes to 116 follow the table, 117 up give -78.3.
// - an output is muted when its bit 7 is zero and its code is 127.
module pmov_top
	import pmov_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// playback and key-click samples
	input  wire logic          play_valid,
	input  wire pmov_stereo_t  play,
	input  wire pmov_stereo_t  beep,
	// converter input stream
	output logic               dac_valid,
	output pmov_stereo_t       dac,
	// analog routing and volume
	output logic [1:0]         dac_vol_route,
	output pmov_drive_t [3:0]  drive,
	output logic [3:0]         ramp_busy
);

	// ************************************************************
	// register storage
	// ************************************************************
	logic [7:0]        route_reg;
	logic [7:0]        dacvol_reg;
	logic [7:0]        vol      [4];
	logic [6:0]        code     [4];
	logic [9:0]        atten_q  [4];
	logic              mute_q   [4];
	logic [3:0]        busy;
	logic signed [15:0] mix_q   [2];
	logic [1:0]        dvr_q;
	logic              dac_valid_q;

	logic              acc;
	logic              wr;
	logic              hit;
	logic [7:0]        idx;
	logic [31:0]       next_rdata;
	logic              next_err;
	logic              tick;
	logic [15:0]       pre_cnt;
	pmov_step_t        step_mode;

	assign idx = paddr[9:2];
	assign hit = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
	assign acc = psel && penable && !pready;
	assign wr  = psel && penable && pready && pwrite && hit;

	// ************************************************************
	// apb slave
	// ************************************************************
	always_comb begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		if (!hit) begin
			next_err = 1'b1;
		end else begin
			case (idx)
				`PMOV_IDX_ROUTE:  next_rdata = {24'h000000, route_reg};
				`PMOV_IDX_DACVOL: next_rdata = {24'h000000, dacvol_reg};
				`PMOV_IDX_HPL:    next_rdata = {24'h000000, vol[0]};
				`PMOV_IDX_HPR:    next_rdata = {24'h000000, vol[1]};
				`PMOV_IDX_SPK:    next_rdata = {24'h000000, vol[2]};
				`PMOV_IDX_AUX:    next_rdata = {24'h000000, vol[3]};
				`PMOV_IDX_STAT: begin
					next_rdata = {busy[3], code[3], busy[2], code[2],
						busy[1], code[1], busy[0], code[0]};
				end
				default:          next_err = 1'b1;
			endcase
		end
	end

	// answer one cycle into the access phase, write lands with pready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc;
			pslverr <= acc && next_err;
			if (acc && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			route_reg <= `PMOV_ROUTE_RST;
		end else if (wr && idx == `PMOV_IDX_ROUTE) begin
			route_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dacvol_reg <= `PMOV_DACVOL_RST;
		end else if (wr && idx == `PMOV_IDX_DACVOL) begin
			dacvol_reg <= pwdata[7:0];
		end
	end

	// ************************************************************
	// digital mixers
	// ************************************************************
	function automatic logic signed [15:0] sat_add(
		input logic signed [15:0] a,
		input logic signed [15:0] b
	);
		logic signed [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15]) begin
			sat_add = s[16] ? 16'sh8000 : 16'sh7fff;
		end else begin
			sat_add = s[15:0];
		end
	endfunction

	logic signed [15:0] pl [2];
	logic signed [15:0] bp [2];

	assign pl[0] = play.left;
	assign pl[1] = play.right;
	assign bp[0] = beep.left;
	assign bp[1] = beep.right;

	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_mix
			pmov_route_t        sel;
			logic signed [16:0] mono_sum;
			logic signed [15:0] first;

			assign sel = pmov_route_t'(route_reg[`PMOV_LROUTE_POS - 2 * c +: 2]);
			assign mono_sum = {pl[0][15], pl[0]} + {pl[1][15], pl[1]};

			// first mixer: select own, crossed or mono data
			always_comb begin
				case (sel)
					PMOV_RT_DIRECT: first = pl[c];
					PMOV_RT_CROSS:  first = pl[1 - c];
					PMOV_RT_MONO:   first = mono_sum[16:1];
					default:        first = 16'sh0000;
				endcase
			end

			// second mixer: tone added after playback level, so the
			// playback volume never scales the key-click
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					mix_q[c] <= 16'sh0000;
				end else if (play_valid) begin
					mix_q[c] <= sat_add(first, bp[c]);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dac_valid_q <= 1'b0;
		end else begin
			dac_valid_q <= play_valid;
		end
	end

	assign dac_valid = dac_valid_q;
	assign dac       = '{left: mix_q[0], right: mix_q[1]};

	// ************************************************************
	// converter to volume routing
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dvr_q <= 2'h0;
		end else begin
			dvr_q <= {dacvol_reg[`PMOV_DACR_BIT],
				dacvol_reg[`PMOV_DACL_BIT]};
		end
	end

	assign dac_vol_route = dvr_q;

	// ************************************************************
	// step pacing, free running so volume works with converters off
	// ************************************************************
	assign step_mode = pmov_step_t'(route_reg[`PMOV_STEP_POS +: 2]);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (pre_cnt == 16'(`PMOV_STEP_CYC - 1)) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	// ************************************************************
	// attenuation in tenths of a dB per code
	// ************************************************************
	function automatic logic [9:0] atten_of(input logic [6:0] v);
		logic [9:0] extra;
		if (v <= 7'h23) begin
			extra = 10'h000;
		end else if (v <= 7'h45) begin
			extra = 10'h001;
		end else if (v <= 7'h53) begin
			extra = 10'h002;
		end else begin
			case (v)
				7'h54: extra = 10'h001;
				7'h55, 7'h56, 7'h5a, 7'h5c, 7'h5d, 7'h60, 7'h61, 7'h68,
				7'h69: extra = 10'h002;
				7'h57, 7'h58, 7'h59, 7'h5b, 7'h62, 7'h64,
				7'h67: extra = 10'h003;
				7'h5e, 7'h5f, 7'h66: extra = 10'h004;
				7'h63, 7'h65: extra = 10'h005;
				7'h6a, 7'h6b: extra = 10'h007;
				7'h6c: extra = 10'h00d;
				7'h6d: extra = 10'h016;
				7'h6e: extra = 10'h021;
				7'h6f: extra = 10'h02f;
				7'h70: extra = 10'h043;
				7'h71: extra = 10'h04e;
				7'h72: extra = 10'h05c;
				7'h73: extra = 10'h070;
				7'h74: extra = 10'h08e;
				default: extra = 10'h000;
			endcase
		end
		if (v >= `PMOV_FLOOR_CODE) begin
			atten_of = `PMOV_FLOOR_ATTEN;
		end else begin
			atten_of = ({3'h0, v} * 10'h005) + extra;
		end
	endfunction

	// ************************************************************
	// four output volume stages
	// ************************************************************
	genvar d;
	generate
		for (d = 0; d < 4; d = d + 1) begin : g_drv
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					vol[d] <= `PMOV_VOL_RST;
				end else if (wr && idx == 8'(`PMOV_IDX_HPL + d)) begin
					vol[d] <= pwdata[7:0];
				end
			end

			pmov_ramp u_ramp (
				.clk    (clk),
				.rst    (rst),
				.tick   (tick),
				.mode   (step_mode),
				.target (vol[d][6:0]),
				.code   (code[d]),
				.busy   (busy[d])
			);

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					atten_q[d] <= `PMOV_FLOOR_ATTEN;
					mute_q[d]  <= 1'b1;
				end else begin
					atten_q[d] <= atten_of(code[d]);
					mute_q[d]  <= !vol[d][`PMOV_AMP_BIT] &&
						(code[d] == `PMOV_MUTE_CODE);
				end
			end

			// each driver has its own code and amplifier switch
			assign drive[d] = '{amp_route: vol[d][`PMOV_AMP_BIT],
				mute: mute_q[d], code: code[d], atten: atten_q[d]};

			mute_rule_a: assert property (
				@(posedge clk) disable iff (rst)
				1'b1 |=> drive[d].mute == ($past(!vol[d][7]) &&
					$past(code[d]) == 7'h7f))
				else $error("mute does not follow route bit and code");

			atten_floor_a: assert property (
				@(posedge clk) disable iff (rst)
				code[d] >= 7'h75 |=> drive[d].atten == 10'h30f)
				else $error("codes from 117 up must give -78.3 dB");
		end
	endgenerate

	assign ramp_busy = busy;

	// ************************************************************
	// checks
	// ************************************************************
	pready_pulse_a: assert property (
		@(posedge clk) disable iff (rst)
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("apb answer is not a single cycle");

	vol_write_a: assert property (
		@(posedge clk) disable iff (rst)
		(wr && idx == 8'h24) |=> vol[0] == $past(pwdata[7:0]))
		else $error("left headphone write not stored");

	swap_path_a: assert property (
		@(posedge clk) disable iff (rst)
		(play_valid && route_reg[5:4] == 2'h2 && beep.left == 16'sh0000)
		|=> dac.left == $past(play.right))
		else $error("crossed routing did not take right data");

	zero_gain_a: assert property (
		@(posedge clk) disable iff (rst)
		code[0] == 7'h00 |=> drive[0].atten == 10'h000)
		else $error("code zero must give 0 dB");

	dac_strobe_a: assert property (
		@(posedge clk) disable iff (rst)
		play_valid |=> dac_valid)
		else $error("mixed sample strobe missing");

	swap_c: cover property (
		@(posedge clk) disable iff (rst)
		play_valid && route_reg[5:2] == 4'ha);

	mono_c: cover property (
		@(posedge clk) disable iff (rst)
		play_valid && route_reg[5:4] == 2'h3);

	ramp_c: cover property (
		@(posedge clk) disable iff (rst)
		busy[0] ##1 !busy[0]);

	mute_c: cover property (
		@(posedge clk) disable iff (rst)
		drive[1].mute);

endmodule

// *** dv/pmov_far_model.sv ***
// far-side model: playback source that feeds the mixers
// assumes the bench calls send once per sample, after reset
`timescale 1ns/10ps

module pmov_far_model
	import pmov_pkg::*;
(
	// clock
	input  wire logic    clk,
	// sample stream toward the mixers
	output logic         play_valid,
	output pmov_stereo_t play,
	output pmov_stereo_t beep
);
	initial begin
		play_valid = 1'b0;
		play = '0;
		beep = '0;
	end

	task automatic send(input logic [31:0] p, input logic [31:0] b,
		input logic last);
		@(posedge clk);
		play_valid <= 1'b1;
		play <= p;
		beep <= b;
		if (last) begin
			@(posedge clk);
			play_valid <= 1'b0;
			// idle lines show the inverse so a stale value never matches
			play <= ~p;
			beep <= ~b;
		end
	endtask
endmodule

// *** dv/playback_mix_and_output_volume_test.sv ***
// self-checking bench for the playback mix and output volume block
// assumes pmov_top with an apb slave and the far-side sample model
`timescale 1ns/10ps
`include "pmov_defines.svh"

module playback_mix_and_output_volume_test
	import pmov_pkg::*;
;
	logic               clk, rst, psel, penable, pwrite;
	logic [31:0]        paddr, pwdata, prdata;
	logic               pready, pslverr, play_valid, dac_valid;
	pmov_stereo_t       play, beep, dac;
	logic [1:0]         dac_vol_route, rt_l, rt_r;
	pmov_drive_t [3:0]  drive;
	logic [3:0]         ramp_busy;
	int                 num_errors, checked;
	int unsigned        seed;
	pmov_stereo_t       expq[$];

	pmov_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .play_valid(play_valid),
		.play(play), .beep(beep), .dac_valid(dac_valid), .dac(dac),
		.dac_vol_route(dac_vol_route), .drive(drive),
		.ramp_busy(ramp_busy));

	pmov_far_model far (.clk(clk), .play_valid(play_valid), .play(play),
		.beep(beep));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($urandom()), d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			chk("pready", 1, 0);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, {22'h0, i, 2'b00}, d, r, e);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] e,
		input logic ee);
		logic [31:0] r;
		logic        er;
		apb(1'b0, a, 8'h00, r, er);
		chk("prdata", e, r);
		chk("pslverr", {31'h0, ee}, {31'h0, er});
	endtask

	function automatic logic [15:0] pick(input logic [1:0] f,
		input logic [15:0] own, input logic [15:0] oth);
		logic [16:0] s;
		s = {own[15], own} + {oth[15], oth};
		case (f)
			2'h0: pick = 16'h0000;
			2'h1: pick = own;
			2'h2: pick = oth;
			default: pick = s[16:1];
		endcase
	endfunction

	function automatic logic [15:0] sat(input logic [15:0] a,
		input logic [15:0] b);
		logic [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15])
			sat = s[16] ? 16'h8000 : 16'h7fff;
		else
			sat = s[15:0];
	endfunction

	task automatic smp(input logic [31:0] p, input logic [31:0] b,
		input logic last);
		pmov_stereo_t e;
		e.left = sat(pick(rt_l, p[31:16], p[15:0]), b[31:16]);
		e.right = sat(pick(rt_r, p[15:0], p[31:16]), b[15:0]);
		expq.push_back(e);
		far.send(p, b, last);
	endtask

	task automatic ramp(input logic [1:0] md, input int per,
		input logic up);
		logic [6:0] c;
		int         n;
		wr(`PMOV_IDX_ROUTE, {2'b00, rt_l, rt_r, 2'b10});
		wr(`PMOV_IDX_HPL, 8'h10);
		repeat (3) @(posedge clk);
		wr(`PMOV_IDX_ROUTE, {2'b00, rt_l, rt_r, md});
		c = 7'h10;
		wr(`PMOV_IDX_HPL, up ? 8'h12 : 8'h0e);
		repeat (2) @(posedge clk);
		chk("ramp_busy", 1, ramp_busy[0]);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			while (drive[0].code === c && n < 9000) begin
				@(posedge clk);
				n++;
			end
			c = up ? c + 7'h01 : c - 7'h01;
			chk("step_code", c, drive[0].code);
			if (k == 1)
				chk("step_time", per, n);
		end
		repeat (3) @(posedge clk);
		chk("ramp_done", 0, ramp_busy[0]);
	endtask

	// ************************************************************
	// clock, watchdog and result monitor
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#1000000;
		num_errors++;
		wrap_up();
	end

	always @(posedge clk) begin
		if (dac_valid === 1'b1) begin
			if (expq.size() == 0)
				chk("dac_extra", 0, 1);
			else
				chk("dac", expq.pop_front(), dac);
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [7:0]  ri[6] = '{8'h3f, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
		logic [7:0]  rv[6] = '{8'h14, 8'h00, 8'h7f, 8'h7f, 8'h7f, 8'h7f};
		logic [6:0]  cd[7] = '{7'h00, 7'h01, 7'h24, 7'h54, 7'h74, 7'h75,
			7'h7f};
		logic [9:0]  at[7] = '{10'h000, 10'h005, 10'h0b5, 10'h1a5,
			10'h2d2, 10'h30f, 10'h30f};
		logic [7:0]  vv[4] = '{8'hff, 8'h85, 8'h03, 8'h40};
		logic [7:0]  dv[4] = '{8'h40, 8'h04, 8'h44, 8'h00};
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		num_errors = 0;
		checked = 0;
		seed = $urandom(32'h6934);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rdc({22'h0, ri[i], 2'b00}, {24'h0, rv[i]}, 1'b0);
		rdc(32'h0000_0100, 32'h0, 1'b1);
		rdc(32'h0000_0091, 32'h0, 1'b1);
		chk("rst_mute", 1, drive[0].mute);
		for (int m = 0; m < 16; m++) begin
			rt_l = m[3:2];
			rt_r = m[1:0];
			wr(`PMOV_IDX_ROUTE, {2'b00, rt_l, rt_r, 2'b10});
			rdc(32'h0fc, {26'h0, rt_l, rt_r, 2'b10}, 1'b0);
			smp(32'h7fff_8000, 32'h7fff_8000, 1'b0);
			// left tone silent so the crossed-path check sees bare data
			smp($urandom(), $urandom() & 32'h0000_ffff, 1'b0);
			smp($urandom(), $urandom(), 1'b1);
		end
		repeat (3) @(posedge clk);
		chk("dac_left", 0, expq.size());
		for (int i = 0; i < 4; i++) begin
			wr(`PMOV_IDX_DACVOL, dv[i]);
			repeat (2) @(posedge clk);
			chk("dac_vol_route", i == 3 ? 0 : i + 1, dac_vol_route);
		end
		for (int i = 0; i < 7; i++) begin
			wr(`PMOV_IDX_HPL, {1'b0, cd[i]});
			repeat (4) @(posedge clk);
			chk("code", cd[i], drive[0].code);
			chk("atten", at[i], drive[0].atten);
			chk("mute", cd[i] == 7'h7f, drive[0].mute);
		end
		for (int i = 0; i < 4; i++)
			wr(`PMOV_IDX_HPL + i[7:0], vv[i]);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			chk("amp_route", vv[i][7], drive[i].amp_route);
			chk("drv_code", vv[i][6:0], drive[i].code);
			rdc({22'h0, `PMOV_IDX_HPL + i[7:0], 2'b00}, vv[i], 1'b0);
		end
		rdc({22'h0, `PMOV_IDX_STAT, 2'b00}, 32'h4003_057f, 1'b0);
		chk("amp_mute", 0, drive[0].mute);
		ramp(2'h0, `PMOV_STEP_CYC, 1'b1);
		ramp(2'h1, 2 * `PMOV_STEP_CYC, 1'b0);
		ramp(2'h3, `PMOV_STEP_CYC, 1'b0);
		// unused speaker and aux outputs are parked muted
		wr(`PMOV_IDX_ROUTE, {2'b00, rt_l, rt_r, 2'b10});
		for (int i = 2; i < 4; i++)
			wr(`PMOV_IDX_HPL + i[7:0], 8'h7f);
		repeat (4) @(posedge clk);
		chk("spk_mute", 1, drive[2].mute);
		chk("aux_mute", 1, drive[3].mute);
		wrap_up();
	end
endmodule
